//--- sbp_pkg.sv
// Package: register map, field positions and carriers for the six-bit port
package sbp_pkg;
   localparam int NPINS = 6;
   localparam int AVS_AW = 8;
   localparam logic [7:0] IDX_PIN_LEVELS = 8'h16;
   localparam logic [7:0] IDX_DIRECTION = 8'h17;
   localparam logic [7:0] IDX_LATCH = 8'h18;
   localparam logic [7:0] IDX_SYSCTL = 8'h35;
   localparam logic [7:0] IDX_ALTCTL = 8'h20;
   localparam logic [7:0] IDX_PCMASK = 8'h21;
   localparam logic [7:0] RST_DIRECTION = 8'h00;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_SYSCTL = 8'h00;
   localparam logic [7:0] RST_ALTCTL = 8'h00;
   localparam logic [7:0] RST_PCMASK = 8'h00;
   localparam logic [7:0] PORT_MASK = 8'h3f;
   localparam logic [7:0] SYSCTL_WMASK = 8'h7b;
   localparam int SYSCTL_PUD = 6;
   localparam int ALT_TWOWIRE = 0;
   localparam int ALT_THREEWIRE = 1;
   localparam int ALT_START_IE = 2;
   localparam int ALT_PC_IE = 3;
   localparam int ALT_CONV1_DD = 4;
   localparam int ALT_CMP_POS_DD = 5;
   localparam int ALT_CMP_NEG_DD = 6;
   localparam int ALT_ANALOG_REFERENCE_PIN = 7;

   typedef struct packed {
      logic pullup_override_enable;
      logic pullup_override_value;
      logic direction_override_enable;
      logic direction_override_value;
      logic pin_value_override_enable;
      logic pin_value_override_value;
      logic input_enable_override_enable;
      logic input_enable_override_value;
      logic force_off;
   } sbp_ovr_s;

   typedef struct packed {
      logic serial_data_out;
      logic serial_clock_hold;
      logic serial_clock_toggle;
      logic timer0_compare_a_out;
      logic timer0_compare_a_en;
      logic timer0_compare_b_out;
      logic timer0_compare_b_en;
      logic timer1_compare_a_out;
      logic timer1_compare_a_en;
   } sbp_alt_s;
endpackage : sbp_pkg

//--- sbp_pin.sv
// One port pin cell: override muxing, pad drive flops and input sampling
`timescale 1ns/1ps
module sbp_pin (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic latch_i,
   input wire logic dir_i,
   input wire logic pud_i,
   input wire sbp_pkg::sbp_ovr_s ovr_i,
   input wire logic pad_i,
   output logic pad_out_o,
   output logic pad_oe_n_o,
   output logic pad_pullup_o,
   output logic din_o,
   output logic din_en_o
);
   logic sync1_reg;
   logic sync2_reg;
   logic pu_next;
   logic dd_next;
   logic pv_next;
   logic ie_next;

   always_comb begin
      pu_next = ovr_i.pullup_override_enable ? ovr_i.pullup_override_value
              : (~dir_i & latch_i & ~pud_i);
      dd_next = ovr_i.direction_override_enable
              ? ovr_i.direction_override_value : dir_i;
      pv_next = ovr_i.pin_value_override_enable
              ? ovr_i.pin_value_override_value : latch_i;
      ie_next = ovr_i.input_enable_override_enable
              ? ovr_i.input_enable_override_value : 1'b1;
      if (ovr_i.force_off) begin
         pu_next = 1'b0;
         dd_next = 1'b0;
      end
   end

   // Pads float with pull-ups off from reset until software configures them
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         pad_out_o <= 1'b0;
         pad_oe_n_o <= 1'b1;
         pad_pullup_o <= 1'b0;
      end else begin
         pad_out_o <= pv_next;
         pad_oe_n_o <= ~dd_next;
         pad_pullup_o <= pu_next;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         din_o <= 1'b0;
         din_en_o <= 1'b1;
      end else begin
         sync1_reg <= pad_i;
         sync2_reg <= sync1_reg;
         // Disabled inputs read zero so analog levels cannot toggle logic
         din_o <= sync2_reg & ie_next;
         din_en_o <= ie_next;
      end
   end
endmodule : sbp_pin

//--- sbp_port.sv
// Six-bit port top: Avalon-MM register slave and alternate function overrides
`timescale 1ns/1ps
module sbp_port (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic [sbp_pkg::AVS_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire sbp_pkg::sbp_alt_s alt_i,
   input wire logic [sbp_pkg::NPINS-1:0] pad_i,
   output logic [sbp_pkg::NPINS-1:0] pad_out_o,
   output logic [sbp_pkg::NPINS-1:0] pad_oe_n_o,
   output logic [sbp_pkg::NPINS-1:0] pad_pullup_o,
   output logic [sbp_pkg::NPINS-1:0] din_o
);
   localparam int N = sbp_pkg::NPINS;

   logic [7:0] latch_reg;
   logic [7:0] dir_reg;
   logic [7:0] sysctl_reg;
   logic [7:0] altctl_reg;
   logic [7:0] pcmask_reg;
   logic [7:0] latch_next;
   logic [7:0] rd_next;
   logic [7:0] wd;
   logic wr_en;
   logic [N-1:0] din_en;
   sbp_pkg::sbp_ovr_s ovr [N];
   logic global_pullup_disable;
   logic tw;
   logic thw;
   logic ssie;
   logic pcie;

   function automatic logic hit(input logic [7:0] idx,
                                input logic [sbp_pkg::AVS_AW-1:0] a);
      hit = ({2'b00, a[sbp_pkg::AVS_AW-1:2]} == idx);
   endfunction : hit

   assign wd = avs_writedata[7:0];
   assign wr_en = avs_write & ~avs_waitrequest & avs_byteenable[0];
   assign global_pullup_disable = sysctl_reg[sbp_pkg::SYSCTL_PUD];
   assign tw = altctl_reg[sbp_pkg::ALT_TWOWIRE];
   assign thw = altctl_reg[sbp_pkg::ALT_THREEWIRE];
   assign ssie = altctl_reg[sbp_pkg::ALT_START_IE];
   assign pcie = altctl_reg[sbp_pkg::ALT_PC_IE];

   // One wait cycle per access; the access completes on the edge after it
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      end
   end

   always_comb begin
      rd_next = 8'h00;
      if (hit(sbp_pkg::IDX_PIN_LEVELS, avs_address)) begin
         rd_next = {2'b00, din_o};
      end else if (hit(sbp_pkg::IDX_DIRECTION, avs_address)) begin
         rd_next = dir_reg;
      end else if (hit(sbp_pkg::IDX_LATCH, avs_address)) begin
         rd_next = latch_reg;
      end else if (hit(sbp_pkg::IDX_SYSCTL, avs_address)) begin
         rd_next = sysctl_reg;
      end else if (hit(sbp_pkg::IDX_ALTCTL, avs_address)) begin
         rd_next = altctl_reg;
      end else if (hit(sbp_pkg::IDX_PCMASK, avs_address)) begin
         rd_next = pcmask_reg;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & avs_waitrequest) begin
         avs_readdata <= {24'h00_0000, rd_next};
      end
   end

   // Writing ones to the pin-level address toggles latch bits; the serial
   // clock toggle strobe flips pin 2's latch the same way
   always_comb begin
      latch_next = latch_reg;
      if (wr_en && hit(sbp_pkg::IDX_LATCH, avs_address)) begin
         latch_next = wd & sbp_pkg::PORT_MASK;
      end
      if (wr_en && hit(sbp_pkg::IDX_PIN_LEVELS, avs_address)) begin
         latch_next = latch_next ^ (wd & sbp_pkg::PORT_MASK);
      end
      latch_next[2] = latch_next[2] ^ alt_i.serial_clock_toggle;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         latch_reg <= sbp_pkg::RST_LATCH;
      end else begin
         latch_reg <= latch_next;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         dir_reg <= sbp_pkg::RST_DIRECTION;
         sysctl_reg <= sbp_pkg::RST_SYSCTL;
         altctl_reg <= sbp_pkg::RST_ALTCTL;
         pcmask_reg <= sbp_pkg::RST_PCMASK;
      end else if (wr_en) begin
         if (hit(sbp_pkg::IDX_DIRECTION, avs_address)) begin
            dir_reg <= wd & sbp_pkg::PORT_MASK;
         end
         if (hit(sbp_pkg::IDX_SYSCTL, avs_address)) begin
            sysctl_reg <= wd & sbp_pkg::SYSCTL_WMASK;
         end
         if (hit(sbp_pkg::IDX_ALTCTL, avs_address)) begin
            altctl_reg <= wd;
         end
         if (hit(sbp_pkg::IDX_PCMASK, avs_address)) begin
            pcmask_reg <= wd & sbp_pkg::PORT_MASK;
         end
      end
   end

   always_comb begin
      for (int i = 0; i < N; i++) begin
         ovr[i] = '0;
      end
      // Pin 0: data line in two-wire mode, comparator positive input
      ovr[0].pullup_override_enable = tw;
      ovr[0].direction_override_enable = tw;
      ovr[0].direction_override_value =
         (alt_i.serial_data_out | latch_reg[0]) & dir_reg[0];
      ovr[0].pin_value_override_enable = alt_i.timer0_compare_a_en
         | alt_i.timer1_compare_a_en | (tw & dir_reg[0]);
      ovr[0].pin_value_override_value =
         alt_i.timer0_compare_a_out | alt_i.timer1_compare_a_out;
      ovr[0].input_enable_override_enable = (pcmask_reg[0] & pcie)
         | altctl_reg[sbp_pkg::ALT_CMP_POS_DD] | ssie;
      ovr[0].input_enable_override_value =
         altctl_reg[sbp_pkg::ALT_CMP_POS_DD];
      ovr[0].force_off = altctl_reg[sbp_pkg::ALT_ANALOG_REFERENCE_PIN];
      // Pin 1: compare outputs and three-wire data out share the driver
      ovr[1].pin_value_override_enable = alt_i.timer0_compare_b_en
         | alt_i.timer1_compare_a_en | thw;
      ovr[1].pin_value_override_value = alt_i.timer0_compare_b_out
         | alt_i.timer1_compare_a_out | alt_i.serial_data_out;
      ovr[1].input_enable_override_enable = (pcmask_reg[1] & pcie)
         | altctl_reg[sbp_pkg::ALT_CMP_NEG_DD];
      ovr[1].input_enable_override_value =
         altctl_reg[sbp_pkg::ALT_CMP_NEG_DD];
      // Pin 2: serial clock, held low by the serial unit when stretching
      ovr[2].pullup_override_enable = tw;
      ovr[2].direction_override_enable = tw;
      ovr[2].direction_override_value =
         (alt_i.serial_clock_hold | latch_reg[2]) & dir_reg[2];
      ovr[2].pin_value_override_enable = tw & dir_reg[2];
      ovr[2].input_enable_override_enable = (pcmask_reg[2] & pcie)
         | altctl_reg[sbp_pkg::ALT_CONV1_DD] | ssie;
      ovr[2].input_enable_override_value =
         altctl_reg[sbp_pkg::ALT_CONV1_DD];
   end

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_pin
         sbp_pin u_pin (
            .sys_clk_i(sys_clk_i),
            .rstn_i(rstn_i),
            .latch_i(latch_reg[g]),
            .dir_i(dir_reg[g]),
            .pud_i(global_pullup_disable),
            .ovr_i(ovr[g]),
            .pad_i(pad_i[g]),
            .pad_out_o(pad_out_o[g]),
            .pad_oe_n_o(pad_oe_n_o[g]),
            .pad_pullup_o(pad_pullup_o[g]),
            .din_o(din_o[g]),
            .din_en_o(din_en[g])
         );
      end
   endgenerate

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);

   sequence s_pud_write;
      avs_write && !avs_waitrequest && avs_byteenable[0]
         && hit(sbp_pkg::IDX_SYSCTL, avs_address)
         && avs_writedata[sbp_pkg::SYSCTL_PUD];
   endsequence

   sequence s_pullups_gone;
      ##1 global_pullup_disable ##1 (pad_pullup_o == '0);
   endsequence

   AST_PUD_WRITE_KILLS_PULLUPS: assert property (
      s_pud_write |-> s_pullups_gone)
      else $error("pull-ups still on after disable bit written");
   AST_PUD_HOLDS: assert property (
      global_pullup_disable |=> pad_pullup_o == '0)
      else $error("pull-up active while disable bit set");
   AST_TW_DIR_PIN0: assert property (
      tw && !altctl_reg[sbp_pkg::ALT_ANALOG_REFERENCE_PIN] |=> pad_oe_n_o[0] ==
      !(($past(alt_i.serial_data_out) | $past(latch_reg[0]))
        & $past(dir_reg[0])))
      else $error("pin 0 two-wire direction wrong");
   AST_IE_PIN0: assert property (
      (pcmask_reg[0] && pcie) || ssie
      || altctl_reg[sbp_pkg::ALT_CMP_POS_DD]
      |=> din_en[0] == $past(altctl_reg[sbp_pkg::ALT_CMP_POS_DD]))
      else $error("pin 0 input enable override wrong");
   AST_IE_PIN1: assert property (
      (pcmask_reg[1] && pcie) || altctl_reg[sbp_pkg::ALT_CMP_NEG_DD]
      |=> din_en[1] == $past(altctl_reg[sbp_pkg::ALT_CMP_NEG_DD]))
      else $error("pin 1 input enable override wrong");
   AST_IE_PIN2: assert property (
      (pcmask_reg[2] && pcie) || ssie || altctl_reg[sbp_pkg::ALT_CONV1_DD]
      |=> din_en[2] == $past(altctl_reg[sbp_pkg::ALT_CONV1_DD]) && !din_o[2]
          == !($past(altctl_reg[sbp_pkg::ALT_CONV1_DD]) && din_o[2]))
      else $error("pin 2 input enable override wrong");
   AST_TW_PIN2: assert property (
      tw |=> !pad_pullup_o[2] && !pad_pullup_o[0] && pad_oe_n_o[2] ==
      !(($past(alt_i.serial_clock_hold) | $past(latch_reg[2]))
        & $past(dir_reg[2])))
      else $error("pin 2 two-wire pull-up or direction wrong");
   AST_PIN1_OR: assert property (
      alt_i.timer0_compare_b_en || alt_i.timer1_compare_a_en |=>
      pad_out_o[1] == $past(alt_i.timer0_compare_b_out
         | alt_i.timer1_compare_a_out | alt_i.serial_data_out))
      else $error("pin 1 compare output wrong");
   AST_THREEWIRE_DO: assert property (
      thw |=> pad_out_o[1] == $past(alt_i.serial_data_out
         | alt_i.timer0_compare_b_out | alt_i.timer1_compare_a_out)
      && pad_oe_n_o[1] == !$past(dir_reg[1])
      && pad_pullup_o[1] == $past(!dir_reg[1] && latch_reg[1] && !global_pullup_disable))
      else $error("pin 1 three-wire drive wrong");
   AST_ANALOG_REFERENCE_PIN_OFF: assert property (
      altctl_reg[sbp_pkg::ALT_ANALOG_REFERENCE_PIN] |=> pad_oe_n_o[0] && !pad_pullup_o[0])
      else $error("pin 0 driven or pulled while reference");
endmodule : sbp_port

//--- sbp_ext_model.sv
// External circuitry model attached to the six port pins
`timescale 1ns/1ps
module sbp_ext_model (
   input wire logic sys_clk_i,
   input wire logic [5:0] pad_out_i,
   input wire logic [5:0] pad_oe_n_i,
   input wire logic [5:0] pad_pullup_i,
   input wire logic [5:0] ext_en_i,
   input wire logic [5:0] ext_val_i,
   output logic [5:0] pad_o
);
   logic [5:0] float_reg = 6'h15;
   // An undriven pin with no pull-up must never look like a stable level
   always_ff @(posedge sys_clk_i) begin
      float_reg <= ~float_reg;
   end
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         pad_o[i] = !pad_oe_n_i[i] ? pad_out_i[i] :
                    ext_en_i[i] ? ext_val_i[i] :
                    pad_pullup_i[i] ? 1'h1 : float_reg[i];
      end
   end
endmodule : sbp_ext_model

//--- tb.sv
// Self-checking bench for the six-bit port and its alternate functions
`timescale 1ns/1ps
module tb;
   logic sys_clk_i = 1'h0;
   logic rstn_i = 1'h0;
   logic [7:0] adr = 8'h00;
   logic rd_s = 1'h0;
   logic wr_s = 1'h0;
   logic [31:0] wdat = 32'h0;
   logic [3:0] be = 4'h0;
   logic [31:0] rdat;
   logic wait_s;
   sbp_pkg::sbp_alt_s alt = '0;
   logic [5:0] pad_i, pad_out, oe_n, pull, din;
   logic [5:0] ext_en = 6'h00;
   logic [5:0] ext_val = 6'h00;
   int error_cnt = 0;
   int num_checks = 0;

   initial begin
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   sbp_port dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .avs_address(adr),
      .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdat),
      .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_s),
      .alt_i(alt), .pad_i(pad_i), .pad_out_o(pad_out), .pad_oe_n_o(oe_n),
      .pad_pullup_o(pull), .din_o(din));
   sbp_ext_model ext (.sys_clk_i(sys_clk_i), .pad_out_i(pad_out),
      .pad_oe_n_i(oe_n), .pad_pullup_i(pull), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .pad_o(pad_i));

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string s, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : wt

   // Request is held until waitrequest is sampled low at an edge
   task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d,
                      input logic [3:0] b, output logic [31:0] q);
      int n;
      @(posedge sys_clk_i);
      adr <= {i[5:0], 2'h0};
      wdat <= {24'h0, d};
      be <= b;
      wr_s <= w;
      rd_s <= !w;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (wait_s !== 1'h0 && n < 40);
      q = rdat;
      wr_s <= 1'h0;
      rd_s <= 1'h0;
      if (n >= 40) begin
         error_cnt++;
         $display("CHECK FAILED bus answer expected 0 seen timeout");
         test_done();
      end
   endtask : acc

   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      logic [31:0] q;
      acc(1'h1, i, d, 4'h1, q);
   endtask : wr

   task automatic rd(input logic [7:0] i, input logic [7:0] e, input string s);
      logic [31:0] q;
      acc(1'h0, i, 8'h00, 4'h1, q);
      chk(s, {24'h0, e}, q);
   endtask : rd

   // Writes altctl, pcmask, direction and latch (not sysctl), then waits for pads and synchronisers
   task automatic cfg(input logic [7:0] a, m, d, l);
      wr(sbp_pkg::IDX_ALTCTL, a);
      wr(sbp_pkg::IDX_PCMASK, m);
      wr(sbp_pkg::IDX_DIRECTION, d);
      wr(sbp_pkg::IDX_LATCH, l);
      wt(8);
   endtask : cfg

   task automatic t_regs();
      logic [31:0] q;
      chk("waitrequest", 1, wait_s);
      chk("reset oe_n", 6'h3f, oe_n);
      chk("reset pullup", 0, pull);
      rd(sbp_pkg::IDX_DIRECTION, 8'h00, "reset dir");
      rd(sbp_pkg::IDX_LATCH, 8'h00, "reset latch");
      rd(sbp_pkg::IDX_SYSCTL, 8'h00, "reset sysctl");
      wr(sbp_pkg::IDX_DIRECTION, 8'hff);
      rd(sbp_pkg::IDX_DIRECTION, 8'h3f, "dir read-only bits");
      wr(sbp_pkg::IDX_SYSCTL, 8'hff);
      rd(sbp_pkg::IDX_SYSCTL, 8'h7b, "sysctl read-only bits");
      wr(sbp_pkg::IDX_SYSCTL, 8'h00);
      acc(1'h1, sbp_pkg::IDX_DIRECTION, 8'h00, 4'h0, q);
      rd(sbp_pkg::IDX_DIRECTION, 8'h3f, "byteenable off");
      wr(8'h3f, 8'hff);
      rd(8'h3f, 8'h00, "unmapped");
   endtask : t_regs

   task automatic t_drive();
      cfg(8'h00, 8'h00, 8'h3f, 8'h2a);
      chk("drive oe_n", 6'h00, oe_n);
      chk("drive out", 6'h2a, pad_out);
      rd(sbp_pkg::IDX_PIN_LEVELS, 8'h2a, "pin levels");
      wr(sbp_pkg::IDX_PIN_LEVELS, 8'h3f);
      wt(4);
      chk("toggled out", 6'h15, pad_out);
      alt.serial_clock_toggle <= 1'h1;
      wt(1);
      alt.serial_clock_toggle <= 1'h0;
      rd(sbp_pkg::IDX_LATCH, 8'h11, "clock toggle latch");
      chk("toggled pin 2", 6'h11, pad_out);
      cfg(8'h00, 8'h00, 8'h00, 8'h3f);
      chk("pullup on", 6'h3f, pull);
      chk("din pulled", 6'h3f, din);
      wr(sbp_pkg::IDX_SYSCTL, 8'h40);
      wt(4);
      chk("pud pullup", 6'h00, pull);
      chk("pud oe_n", 6'h3f, oe_n);
      wr(sbp_pkg::IDX_SYSCTL, 8'h00);
   endtask : t_drive

   task automatic t_die();
      logic [7:0] a [4] = '{8'h08, 8'h04, 8'h78, 8'h08};
      logic [7:0] m [4] = '{8'h07, 8'h00, 8'h07, 8'h38};
      logic [5:0] e [4] = '{6'h38, 6'h3a, 6'h3f, 6'h3f};
      for (int k = 0; k < 4; k++) begin
         cfg(a[k], m[k], 8'h00, 8'h3f);
         chk("din override", e[k], din);
      end
   endtask : t_die

   task automatic t_two();
      cfg(8'h01, 8'h00, 8'h05, 8'h05);
      chk("tw pullup", 6'h00, pull & 6'h05);
      chk("tw oe_n", 6'h00, oe_n & 6'h05);
      chk("tw out", 6'h00, pad_out & 6'h05);
      cfg(8'h01, 8'h00, 8'h05, 8'h00);
      chk("tw release", 6'h05, oe_n & 6'h05);
      alt.serial_data_out <= 1'h1;
      wt(4);
      chk("tw data", 6'h04, oe_n & 6'h05);
      alt.serial_data_out <= 1'h0;
      alt.serial_clock_hold <= 1'h1;
      wt(4);
      chk("tw hold", 6'h01, oe_n & 6'h05);
      alt.serial_clock_hold <= 1'h0;
      cfg(8'h01, 8'h00, 8'h00, 8'h05);
      chk("tw input", 6'h05, oe_n & 6'h05);
      chk("tw in pullup", 6'h00, pull & 6'h05);
      cfg(8'h01, 8'h00, 8'h02, 8'h02);
      alt.timer1_compare_a_en <= 1'h1;
      wt(4);
      chk("pin1 cmp low", 0, pad_out[1]);
      alt.timer0_compare_b_en <= 1'h1;
      alt.timer0_compare_b_out <= 1'h1;
      wt(4);
      chk("pin1 cmp high", 1, pad_out[1]);
      alt.timer0_compare_a_en <= 1'h1;
      alt.timer0_compare_a_out <= 1'h1;
      wt(4);
      chk("pin0 cmp high", 1, pad_out[0]);
      alt <= '0;
   endtask : t_two

   task automatic t_three();
      cfg(8'h02, 8'h00, 8'h02, 8'h00);
      alt.serial_data_out <= 1'h1;
      wt(4);
      chk("3w out", 1, pad_out[1]);
      chk("3w oe_n", 0, oe_n[1]);
      cfg(8'h02, 8'h00, 8'h00, 8'h02);
      chk("3w input", 1, oe_n[1]);
      chk("3w pullup", 1, pull[1]);
      alt.serial_data_out <= 1'h0;
      ext_en <= 6'h01;
      wt(8);
      chk("3w din low", 0, din[0]);
      ext_val <= 6'h01;
      wt(8);
      chk("3w din high", 1, din[0]);
      ext_en <= 6'h00;
   endtask : t_three

   task automatic t_analog_reference_pin();
      cfg(8'h80, 8'h00, 8'h01, 8'h01);
      chk("analog_reference_pin oe_n", 1, oe_n[0]);
      chk("analog_reference_pin pullup", 0, pull[0]);
      cfg(8'h80, 8'h00, 8'h00, 8'h01);
      chk("analog_reference_pin in pullup", 0, pull[0]);
   endtask : t_analog_reference_pin

   // Mid-run reset must return every output to its idle value
   task automatic t_reset();
      rstn_i <= 1'h0;
      wt(2);
      chk("rst waitrequest", 1, wait_s);
      chk("rst oe_n", 6'h3f, oe_n);
      chk("rst out", 0, pad_out);
      chk("rst pullup", 0, pull);
      chk("rst din", 0, din);
      chk("rst rdata", 0, rdat);
      rstn_i <= 1'h1;
      rd(sbp_pkg::IDX_ALTCTL, 8'h00, "rst altctl");
   endtask : t_reset

   initial begin
      wt(5);
      rstn_i <= 1'h1;
      t_regs();
      t_drive();
      t_die();
      t_two();
      t_three();
      t_analog_reference_pin();
      t_reset();
      test_done();
   end
endmodule : tb
